// file: rx_fmt_flow.sv
// one channel of receive character format and receive flow control
// Contract
// - receive bit rate selectable per channel from 300 to 38400 in doublings
// - reset sets receive bit rate to 9600
// - 5 to 8 data bits, one setting shared by transmit and receive
// - reset sets data width to 8 bits
// - upper threshold 1..size-3, otherwise error and load size/3
// - lower threshold 1..size-1, otherwise error and load 2*size/3
// - reset sets upper threshold to buffer size minus 1024
// - reset sets lower threshold to buffer size minus 2048
// - reaching upper threshold sends XOFF if paced, drops fill-mode outputs
// - falling to lower threshold sends XON if paced, raises fill outputs
// - XON is code 17, XOFF is code 19
// - pacing is XON/XOFF or none; none sends nothing; reset selects none
// - parity setting is shared by transmitter and receiver
// - even or odd: transmit parity appended, receive parity checked
// - no parity: nothing sent, nothing checked
// - ignore mode keeps previous transmit parity, hides receive parity errors
// - forced zero or one parity sent and checked as that constant
// - reset sets parity to none
`default_nettype none
module rx_fmt_flow #(
    parameter int CLK_HZ = 100_000_000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial line
    input wire logic rxd,
    // configuration writes
    input wire logic cfg_baud_we,
    input wire logic [2:0] cfg_baud,
    input wire logic cfg_bits_we,
    input wire logic [1:0] cfg_bits,
    input wire logic cfg_par_we,
    input wire logic [2:0] cfg_par,
    input wire logic cfg_pace_we,
    input wire logic cfg_pace,
    input wire logic cfg_hi_we,
    input wire logic [rx_fmt_pkg::CNT_W-1:0] cfg_hi,
    input wire logic cfg_lo_we,
    input wire logic [rx_fmt_pkg::CNT_W-1:0] cfg_lo,
    input wire logic [rx_fmt_pkg::CNT_W-1:0] buf_size,
    // modem-control line setup
    input wire logic rts_fill_mode,
    input wire logic rts_level,
    input wire logic dtr_fill_mode,
    input wire logic dtr_level,
    // buffer drain and transmit hand-off
    input wire logic buf_pop,
    input wire logic flow_ack,
    // current settings
    output logic [2:0] baud_sel,
    output logic [1:0] bits_sel,
    output logic [2:0] tx_parity,
    output logic parity_ignore,
    output logic pace_xon,
    output logic [rx_fmt_pkg::CNT_W-1:0] thr_hi,
    output logic [rx_fmt_pkg::CNT_W-1:0] thr_lo,
    output logic thr_err,
    // received characters
    output logic [rx_fmt_pkg::CHR_W-1:0] rx_data,
    output logic rx_valid,
    output logic parity_err,
    output logic frame_err,
    output logic [rx_fmt_pkg::CNT_W-1:0] buf_count,
    // flow control
    output logic flow_req,
    output logic [rx_fmt_pkg::CHR_W-1:0] flow_char,
    output logic rts_out,
    output logic dtr_out
);

    // ------------------------------------------------------------------
    // bit period
    // ------------------------------------------------------------------
    localparam logic [rx_fmt_pkg::DIV_W-1:0] DIV_BASE =
        rx_fmt_pkg::DIV_W'(CLK_HZ / rx_fmt_pkg::BAUD_MIN);

    // ------------------------------------------------------------------
    // settings
    // ------------------------------------------------------------------
    logic [2:0] baud_r;
    logic [1:0] bits_r;
    rx_fmt_pkg::par_t par_r;
    logic ign_r;
    logic pace_r;
    logic [rx_fmt_pkg::CNT_W-1:0] hi_r;
    logic [rx_fmt_pkg::CNT_W-1:0] lo_r;
    logic err_r;

    wire logic hi_ok;
    wire logic lo_ok;
    wire logic [rx_fmt_pkg::CNT_W-1:0] third;
    wire logic [rx_fmt_pkg::CNT_W-1:0] two_thirds;
    wire logic par_legal;
    assign third = buf_size / rx_fmt_pkg::THR_DIV;
    assign two_thirds = third + third;
    assign hi_ok = cfg_hi >= rx_fmt_pkg::THR_MIN &&
        cfg_hi <= buf_size - rx_fmt_pkg::HI_MARGIN;
    assign lo_ok = cfg_lo >= rx_fmt_pkg::THR_MIN &&
        cfg_lo <= buf_size - rx_fmt_pkg::LO_MARGIN;
    assign par_legal = cfg_par <= rx_fmt_pkg::PAR_IGN;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            baud_r <= rx_fmt_pkg::BAUD_RST;
            bits_r <= rx_fmt_pkg::BITS_RST;
        end else begin
            if (cfg_baud_we) begin
                baud_r <= cfg_baud;
            end
            if (cfg_bits_we) begin
                bits_r <= cfg_bits;
            end
        end
    end

    // ignore mode leaves the transmit parity as it was
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            par_r <= rx_fmt_pkg::PAR_NONE;
            ign_r <= 1'b0;
            pace_r <= 1'b0;
        end else begin
            if (cfg_par_we && par_legal) begin
                if (cfg_par == rx_fmt_pkg::PAR_IGN) begin
                    ign_r <= 1'b1;
                end else begin
                    par_r <= rx_fmt_pkg::par_t'(cfg_par);
                    ign_r <= 1'b0;
                end
            end
            if (cfg_pace_we) begin
                pace_r <= cfg_pace;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hi_r <= buf_size - rx_fmt_pkg::HI_RST_OFS;
            lo_r <= buf_size - rx_fmt_pkg::LO_RST_OFS;
            err_r <= 1'b0;
        end else begin
            err_r <= (cfg_hi_we && !hi_ok) || (cfg_lo_we && !lo_ok);
            if (cfg_hi_we) begin
                hi_r <= hi_ok ? cfg_hi : third;
            end
            if (cfg_lo_we) begin
                lo_r <= lo_ok ? cfg_lo : two_thirds;
            end
        end
    end

    // ------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------
    rx_fmt_pkg::rx_st_t st_r;
    rx_fmt_pkg::rx_st_t st_nxt;
    logic [rx_fmt_pkg::DIV_W-1:0] tick_r;
    logic [rx_fmt_pkg::DIV_W-1:0] tick_nxt;
    logic [3:0] nbit_r;
    logic [3:0] nbit_nxt;
    logic [rx_fmt_pkg::CHR_W-1:0] sh_r;
    logic [rx_fmt_pkg::CHR_W-1:0] sh_nxt;
    logic pbit_r;
    logic pbit_nxt;
    logic done;

    wire logic [rx_fmt_pkg::DIV_W-1:0] bit_div;
    wire logic [rx_fmt_pkg::DIV_W-1:0] half_div;
    wire logic [3:0] nbits;
    wire logic par_used;
    wire logic tick0;
    wire logic [rx_fmt_pkg::CHR_W-1:0] aligned;
    wire logic par_exp;

    assign bit_div = DIV_BASE >> baud_r;
    assign half_div = bit_div >> 1;
    assign nbits = rx_fmt_pkg::BITS_BASE + {2'h0, bits_r};
    assign par_used = par_r != rx_fmt_pkg::PAR_NONE;
    assign tick0 = tick_r == '0;
    // data enters at the top, so short characters sit high until aligned
    assign aligned = sh_r >> (rx_fmt_pkg::BITS_FULL - nbits);
    assign par_exp = (par_r == rx_fmt_pkg::PAR_EVEN) ? ^aligned :
        (par_r == rx_fmt_pkg::PAR_ODD) ? ~^aligned :
        (par_r == rx_fmt_pkg::PAR_ONE);

    always_comb begin
        st_nxt = st_r;
        tick_nxt = tick0 ? '0 : tick_r - 1'b1;
        nbit_nxt = nbit_r;
        sh_nxt = sh_r;
        pbit_nxt = pbit_r;
        done = 1'b0;
        unique case (st_r)
            rx_fmt_pkg::ST_IDLE: begin
                if (!rxd) begin
                    st_nxt = rx_fmt_pkg::ST_START;
                    tick_nxt = half_div;
                end
            end
            rx_fmt_pkg::ST_START: begin
                if (tick0) begin
                    // a start bit gone by mid-bit was a glitch
                    st_nxt = rxd ? rx_fmt_pkg::ST_IDLE : rx_fmt_pkg::ST_DATA;
                    tick_nxt = bit_div - 1'b1;
                    nbit_nxt = '0;
                end
            end
            rx_fmt_pkg::ST_DATA: begin
                if (tick0) begin
                    sh_nxt = {rxd, sh_r[rx_fmt_pkg::CHR_W-1:1]};
                    nbit_nxt = nbit_r + 1'b1;
                    tick_nxt = bit_div - 1'b1;
                    if (nbit_r == nbits - 1'b1) begin
                        st_nxt = par_used ? rx_fmt_pkg::ST_PAR :
                            rx_fmt_pkg::ST_STOP;
                    end
                end
            end
            rx_fmt_pkg::ST_PAR: begin
                if (tick0) begin
                    pbit_nxt = rxd;
                    tick_nxt = bit_div - 1'b1;
                    st_nxt = rx_fmt_pkg::ST_STOP;
                end
            end
            rx_fmt_pkg::ST_STOP: begin
                if (tick0) begin
                    done = 1'b1;
                    st_nxt = rx_fmt_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = rx_fmt_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= rx_fmt_pkg::ST_IDLE;
            tick_r <= '0;
            nbit_r <= '0;
            sh_r <= '0;
            pbit_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tick_r <= tick_nxt;
            nbit_r <= nbit_nxt;
            sh_r <= sh_nxt;
            pbit_r <= pbit_nxt;
        end
    end

    logic [rx_fmt_pkg::CHR_W-1:0] data_r;
    logic valid_r;
    logic perr_r;
    logic ferr_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_r <= '0;
            valid_r <= 1'b0;
            perr_r <= 1'b0;
            ferr_r <= 1'b0;
        end else begin
            valid_r <= done;
            if (done) begin
                data_r <= aligned;
                // a missing stop bit is the usual sign of unexpected parity
                ferr_r <= !rxd;
                perr_r <= par_used && !ign_r && pbit_r != par_exp;
            end
        end
    end

    // ------------------------------------------------------------------
    // occupancy and flow control
    // ------------------------------------------------------------------
    logic [rx_fmt_pkg::CNT_W-1:0] cnt_r;
    logic [rx_fmt_pkg::CNT_W-1:0] cnt_nxt;
    logic above_r;
    logic freq_r;
    logic [rx_fmt_pkg::CHR_W-1:0] fchar_r;
    logic rts_r;
    logic dtr_r;

    wire logic push;
    wire logic pop;
    wire logic hi_hit;
    wire logic lo_hit;
    wire logic above_nxt;
    assign push = valid_r && cnt_r != buf_size;
    assign pop = buf_pop && cnt_r != '0;
    assign hi_hit = !above_r && cnt_r >= hi_r;
    assign lo_hit = above_r && cnt_r <= lo_r;
    assign above_nxt = hi_hit ? 1'b1 : lo_hit ? 1'b0 : above_r;

    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // a new threshold event wins over an acknowledge in the same cycle;
    // the transmitter takes the request between characters
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            above_r <= 1'b0;
            freq_r <= 1'b0;
            fchar_r <= rx_fmt_pkg::XON_CHAR;
        end else begin
            cnt_r <= cnt_nxt;
            above_r <= above_nxt;
            if (pace_r && hi_hit) begin
                freq_r <= 1'b1;
                fchar_r <= rx_fmt_pkg::XOFF_CHAR;
            end else if (pace_r && lo_hit) begin
                freq_r <= 1'b1;
                fchar_r <= rx_fmt_pkg::XON_CHAR;
            end else if (flow_ack || !pace_r) begin
                freq_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rts_r <= 1'b0;
            dtr_r <= 1'b0;
        end else begin
            rts_r <= rts_fill_mode ? !above_nxt : rts_level;
            dtr_r <= dtr_fill_mode ? !above_nxt : dtr_level;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign baud_sel = baud_r;
    assign bits_sel = bits_r;
    assign tx_parity = par_r;
    assign parity_ignore = ign_r;
    assign pace_xon = pace_r;
    assign thr_hi = hi_r;
    assign thr_lo = lo_r;
    assign thr_err = err_r;
    assign rx_data = data_r;
    assign rx_valid = valid_r;
    assign parity_err = perr_r;
    assign frame_err = ferr_r;
    assign buf_count = cnt_r;
    assign flow_req = freq_r;
    assign flow_char = fchar_r;
    assign rts_out = rts_r;
    assign dtr_out = dtr_r;

endmodule
`default_nettype wire

// file: rx_fmt_flow_sva.sv
// assertion checker for the receive format and flow control block
`default_nettype none
module rx_fmt_flow_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration and drain
    input wire logic cfg_baud_we,
    input wire logic [2:0] cfg_baud,
    input wire logic cfg_par_we,
    input wire logic [2:0] cfg_par,
    input wire logic cfg_hi_we,
    input wire logic [rx_fmt_pkg::CNT_W-1:0] cfg_hi,
    input wire logic cfg_lo_we,
    input wire logic [rx_fmt_pkg::CNT_W-1:0] cfg_lo,
    input wire logic [rx_fmt_pkg::CNT_W-1:0] buf_size,
    input wire logic rts_fill_mode,
    input wire logic buf_pop,
    // observed outputs
    input wire logic [2:0] baud_sel,
    input wire logic [2:0] tx_parity,
    input wire logic parity_ignore,
    input wire logic pace_xon,
    input wire logic [rx_fmt_pkg::CNT_W-1:0] thr_hi,
    input wire logic [rx_fmt_pkg::CNT_W-1:0] thr_lo,
    input wire logic thr_err,
    input wire logic rx_valid,
    input wire logic parity_err,
    input wire logic [rx_fmt_pkg::CNT_W-1:0] buf_count,
    input wire logic flow_req,
    input wire logic [rx_fmt_pkg::CHR_W-1:0] flow_char,
    input wire logic rts_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic hit_hi = buf_count >= thr_hi;
    wire logic [rx_fmt_pkg::CNT_W-1:0] third = buf_size / rx_fmt_pkg::THR_DIV;

    property p_baud;
        cfg_baud_we |=> baud_sel == $past(cfg_baud);
    endproperty
    a_baud: assert property (p_baud) else $error("rate not loaded");
    property p_par;
        cfg_par_we && cfg_par < 3'h5
            |=> tx_parity == $past(cfg_par) && !parity_ignore;
    endproperty
    a_par: assert property (p_par) else $error("parity not loaded");
    property p_ign;
        cfg_par_we && cfg_par == 3'h5 |=> parity_ignore && $stable(tx_parity);
    endproperty
    a_ign: assert property (p_ign) else $error("ignore lost parity");
    property p_hi_bad;
        cfg_hi_we && cfg_hi == '0 |=> thr_err && thr_hi == third;
    endproperty
    a_hi_bad: assert property (p_hi_bad) else $error("bad upper kept");
    property p_lo_bad;
        cfg_lo_we && cfg_lo >= buf_size |=> thr_err && thr_lo == (third << 1);
    endproperty
    a_lo_bad: assert property (p_lo_bad) else $error("bad lower kept");
    property p_cnt;
        rx_valid && !buf_pop && buf_count < buf_size
            |=> buf_count == $past(buf_count) + 1'b1;
    endproperty
    a_cnt: assert property (p_cnt) else $error("count missed a store");
    property p_pop;
        buf_pop && !rx_valid && buf_count != '0
            |=> buf_count == $past(buf_count) - 1'b1;
    endproperty
    a_pop: assert property (p_pop) else $error("count missed a pop");
    property p_xoff;
        pace_xon && $rose(hit_hi)
            |=> flow_req && flow_char == rx_fmt_pkg::XOFF_CHAR;
    endproperty
    a_xoff: assert property (p_xoff) else $error("no XOFF sent");
    property p_rts;
        rts_fill_mode && $rose(hit_hi) |=> !rts_out;
    endproperty
    a_rts: assert property (p_rts) else $error("rts kept at upper fill");
    property p_xon;
        pace_xon && flow_char == rx_fmt_pkg::XOFF_CHAR && buf_count <= thr_lo
            |=> flow_req && flow_char == rx_fmt_pkg::XON_CHAR;
    endproperty
    a_xon: assert property (p_xon) else $error("no XON sent");
    property p_quiet;
        !pace_xon [*2] |-> !flow_req;
    endproperty
    a_quiet: assert property (p_quiet) else $error("unpaced flow");
    property p_noerr;
        parity_ignore [*2] ##0 rx_valid |-> !parity_err;
    endproperty
    a_noerr: assert property (p_noerr) else $error("error not hidden");
    c_xoff: cover property (flow_req && flow_char == rx_fmt_pkg::XOFF_CHAR);
    c_perr: cover property (rx_valid && parity_err);
    c_terr: cover property (thr_err);
endmodule

bind rx_fmt_flow rx_fmt_flow_chk chk_u (.clk(clk), .rst_n(rst_n),
    .cfg_baud_we(cfg_baud_we), .cfg_baud(cfg_baud), .cfg_par_we(cfg_par_we),
    .cfg_par(cfg_par), .cfg_hi_we(cfg_hi_we), .cfg_hi(cfg_hi),
    .cfg_lo_we(cfg_lo_we), .cfg_lo(cfg_lo), .buf_size(buf_size),
    .rts_fill_mode(rts_fill_mode), .buf_pop(buf_pop), .baud_sel(baud_sel),
    .tx_parity(tx_parity), .parity_ignore(parity_ignore), .pace_xon(pace_xon),
    .thr_hi(thr_hi), .thr_lo(thr_lo), .thr_err(thr_err), .rx_valid(rx_valid),
    .parity_err(parity_err), .buf_count(buf_count), .flow_req(flow_req),
    .flow_char(flow_char), .rts_out(rts_out));
`default_nettype wire

// file: rx_fmt_pkg.sv
// constants and types for the receive format and flow control block
`default_nettype none
package rx_fmt_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int CNT_W = 20;
    localparam int DIV_W = 24;
    localparam int CHR_W = 8;

    // ------------------------------------------------------------------
    // bit rate: rate = BAUD_MIN << sel, sel 0..7 gives 300..38400
    // ------------------------------------------------------------------
    localparam int BAUD_MIN = 300;
    localparam logic [2:0] BAUD_RST = 3'h5;
    localparam logic [2:0] BAUD_MAX_SEL = 3'h7;

    // ------------------------------------------------------------------
    // character width: sel 0..3 means 5..8 data bits
    // ------------------------------------------------------------------
    localparam logic [3:0] BITS_BASE = 4'h5;
    localparam logic [3:0] BITS_FULL = 4'h8;
    localparam logic [1:0] BITS_RST = 2'h3;

    // ------------------------------------------------------------------
    // parity modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PAR_NONE = 3'h0,
        PAR_EVEN = 3'h1,
        PAR_ODD = 3'h2,
        PAR_ZERO = 3'h3,
        PAR_ONE = 3'h4,
        PAR_IGN = 3'h5
    } par_t;

    // ------------------------------------------------------------------
    // fill thresholds and flow characters
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] THR_MIN = 20'h00001;
    localparam logic [CNT_W-1:0] HI_MARGIN = 20'h00003;
    localparam logic [CNT_W-1:0] LO_MARGIN = 20'h00001;
    localparam logic [CNT_W-1:0] HI_RST_OFS = 20'h00400;
    localparam logic [CNT_W-1:0] LO_RST_OFS = 20'h00800;
    localparam logic [CNT_W-1:0] THR_DIV = 20'h00003;
    localparam logic [CHR_W-1:0] XON_CHAR = 8'h11;
    localparam logic [CHR_W-1:0] XOFF_CHAR = 8'h13;

    // ------------------------------------------------------------------
    // receiver states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_START = 5'h02,
        ST_DATA = 5'h04,
        ST_PAR = 5'h08,
        ST_STOP = 5'h10
    } rx_st_t;

endpackage
`default_nettype wire

// file: serial_term.sv
// remote terminal model that sends characters on the receive line
`default_nettype none
module serial_term (
    // clock
    input wire logic clk,
    // serial line, marking when idle
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd = 1'b1;
    // start, data lsb first, optional parity, one stop, one idle bit
    task automatic send(input logic [7:0] d, input int nb, input logic pe,
                        input logic pb, input int bc);
        logic q[$];
        q.push_back(1'b0);
        for (int i = 0; i < nb; i++) q.push_back(d[i]);
        if (pe) q.push_back(pb);
        q.push_back(1'b1);
        q.push_back(1'b1);
        foreach (q[i]) begin
            @(negedge clk);
            rxd = q[i];
            repeat (bc - 1) @(negedge clk);
        end
    endtask
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the receive format and flow control block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // stimulus and wiring
    // ------------------------------------------------------------------
    localparam int BIT0 = 2048;
    localparam logic [19:0] SIZE = 20'h00C00;
    typedef struct packed {
        logic [2:0] baud; logic [1:0] bits; logic [2:0] par; logic [7:0] d;
        logic pe; logic pf; logic ep; logic ef;
    } row_t;
    // rate, width, parity, data, parity sent, parity flipped, errors
    row_t rows [8] = '{
        '{3'h7, 2'h3, 3'h0, 8'hA5, 1'h0, 1'h0, 1'h0, 1'h0},
        '{3'h6, 2'h0, 3'h1, 8'h13, 1'h1, 1'h0, 1'h0, 1'h0},
        '{3'h7, 2'h1, 3'h2, 8'h2A, 1'h1, 1'h0, 1'h0, 1'h0},
        '{3'h7, 2'h2, 3'h3, 8'h55, 1'h1, 1'h1, 1'h1, 1'h0},
        '{3'h7, 2'h3, 3'h4, 8'hC3, 1'h1, 1'h0, 1'h0, 1'h0},
        '{3'h7, 2'h3, 3'h1, 8'h81, 1'h1, 1'h1, 1'h1, 1'h0},
        '{3'h7, 2'h3, 3'h5, 8'h81, 1'h1, 1'h1, 1'h0, 1'h0},
        '{3'h7, 2'h3, 3'h0, 8'h7E, 1'h1, 1'h0, 1'h0, 1'h1}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wire logic rxd;
    logic baud_we = 0, bits_we = 0, par_we = 0, pace_we = 0, pace = 0;
    logic hi_we = 0, lo_we = 0, rts_fm = 0, dtr_fm = 0, pop = 0, ack = 0;
    logic rts_lv = 0, dtr_lv = 1;
    logic [2:0] baud = 0, par = 0, baud_sel, tx_parity;
    logic [1:0] bits = 0, bits_sel;
    logic [19:0] hi = 0, lo = 0, thr_hi, thr_lo, buf_count;
    logic [7:0] rx_data, flow_char;
    logic ign, pace_xon, thr_err, rx_valid, parity_err, frame_err, flow_req;
    logic rts_out, dtr_out;
    int fail_count = 0;
    int compares = 0;
    always #5 clk = ~clk;
    serial_term term_u (.clk(clk), .rxd(rxd));
    rx_fmt_flow #(.CLK_HZ(614400)) dut_u (.clk(clk), .rst_n(rst_n),
        .rxd(rxd), .cfg_baud_we(baud_we), .cfg_baud(baud),
        .cfg_bits_we(bits_we), .cfg_bits(bits), .cfg_par_we(par_we),
        .cfg_par(par), .cfg_pace_we(pace_we), .cfg_pace(pace),
        .cfg_hi_we(hi_we), .cfg_hi(hi), .cfg_lo_we(lo_we), .cfg_lo(lo),
        .buf_size(SIZE), .rts_fill_mode(rts_fm), .rts_level(rts_lv),
        .dtr_fill_mode(dtr_fm), .dtr_level(dtr_lv), .buf_pop(pop),
        .flow_ack(ack), .baud_sel(baud_sel), .bits_sel(bits_sel),
        .tx_parity(tx_parity), .parity_ignore(ign), .pace_xon(pace_xon),
        .thr_hi(thr_hi), .thr_lo(thr_lo), .thr_err(thr_err),
        .rx_data(rx_data), .rx_valid(rx_valid), .parity_err(parity_err),
        .frame_err(frame_err), .buf_count(buf_count), .flow_req(flow_req),
        .flow_char(flow_char), .rts_out(rts_out), .dtr_out(dtr_out));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [19:0] e,
                       input logic [19:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr_fmt(input logic [2:0] b, input logic [1:0] w,
                          input logic [2:0] p);
        @(negedge clk);
        {baud_we, bits_we, par_we, baud, bits, par} = {3'h7, b, w, p};
        @(negedge clk);
        {baud_we, bits_we, par_we} = 3'h0;
    endtask
    task automatic wr_thr(input logic hw, input logic [19:0] h,
                          input logic lw, input logic [19:0] l);
        @(negedge clk);
        {hi_we, hi, lo_we, lo} = {hw, h, lw, l};
        @(negedge clk);
        {hi_we, lo_we} = 2'h0;
    endtask
    task automatic strobe_pop();
        pop = 1'b1;
        cyc(1);
        pop = 1'b0;
        cyc(1);
    endtask
    task automatic strobe_ack();
        ack = 1'b1;
        cyc(1);
        ack = 1'b0;
        cyc(1);
    endtask
    task automatic rx_one(input logic [7:0] d, input logic [1:0] w,
                          input logic pe, input logic pb, input logic [2:0] b);
        int k;
        fork
            term_u.send(d, 5 + w, pe, pb, BIT0 >> b);
            begin
                for (k = 0; k < 40000; k++) begin
                    @(negedge clk);
                    if (rx_valid === 1'b1) break;
                end
                if (k == 40000) begin
                    chk("rx_valid", 20'h00001, 20'h00000);
                    finish_test();
                end
            end
        join
    endtask
    function automatic logic pbit(input logic [2:0] m, input logic [7:0] d);
        case (m)
            3'h1: return ^d;
            3'h2: return ~^d;
            3'h4: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    task automatic chk_rst();
        chk("baud_sel", 20'h00005, baud_sel);
        chk("bits_sel", 20'h00003, bits_sel);
        chk("tx_parity", 20'h00000, tx_parity);
        chk("pace_xon", 20'h00000, pace_xon);
        chk("thr_hi", SIZE - rx_fmt_pkg::HI_RST_OFS, thr_hi);
        chk("thr_lo", SIZE - rx_fmt_pkg::LO_RST_OFS, thr_lo);
        chk("buf_count", 20'h00000, buf_count);
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        row_t r;
        logic [2:0] eff;
        logic [7:0] dm;
        int i;
        cyc(4);
        rst_n = 1'b1;
        cyc(1);
        chk_rst();
        for (i = 0; i < 8; i++) begin
            wr_fmt(i[2:0], 2'h3, 3'h0);
            chk("baud_sel", i[2:0], baud_sel);
        end
        eff = 3'h0;
        for (i = 0; i < 8; i++) begin
            r = rows[i];
            wr_fmt(r.baud, r.bits, r.par);
            if (r.par != 3'h5) eff = r.par;
            dm = r.d & (8'hFF >> (3 - r.bits));
            chk("bits_sel", r.bits, bits_sel);
            chk("tx_parity", eff, tx_parity);
            chk("parity_ignore", r.par == 3'h5, ign);
            rx_one(dm, r.bits, r.pe, pbit(eff, dm) ^ r.pf, r.baud);
            chk("rx_data", dm, rx_data);
            chk("parity_err", r.ep, parity_err);
            chk("frame_err", r.ef, frame_err);
        end
        chk("buf_count", 20'h00008, buf_count);
        wr_fmt(3'h7, 2'h3, 3'h6);
        chk("tx_parity", 20'h00000, tx_parity);
        for (i = 0; i < 8; i++) strobe_pop();
        chk("buf_count", 20'h00000, buf_count);
        wr_thr(1'b1, 20'h00004, 1'b1, 20'h00002);
        chk("thr_err", 20'h00000, thr_err);
        pace = 1'b1;
        pace_we = 1'b1;
        rts_fm = 1'b1;
        cyc(1);
        pace_we = 1'b0;
        cyc(2);
        chk("rts_out", 20'h00001, rts_out);
        for (i = 0; i < 4; i++) rx_one(8'h41, 2'h3, 1'b0, 1'b0, 3'h7);
        chk("flow_req", 20'h00001, flow_req);
        chk("flow_char", 20'h00013, flow_char);
        chk("rts_out", 20'h00000, rts_out);
        chk("dtr_out", 20'h00001, dtr_out);
        strobe_ack();
        chk("flow_req", 20'h00000, flow_req);
        strobe_pop();
        strobe_pop();
        cyc(1);
        chk("flow_char", 20'h00011, flow_char);
        chk("flow_req", 20'h00001, flow_req);
        chk("rts_out", 20'h00001, rts_out);
        strobe_ack();
        pace = 1'b0;
        pace_we = 1'b1;
        cyc(1);
        pace_we = 1'b0;
        for (i = 0; i < 2; i++) rx_one(8'h42, 2'h3, 1'b0, 1'b0, 3'h7);
        cyc(2);
        chk("flow_req", 20'h00000, flow_req);
        chk("rts_out", 20'h00000, rts_out);
        wr_thr(1'b1, 20'h00000, 1'b0, 20'h00000);
        chk("thr_err", 20'h00001, thr_err);
        chk("thr_hi", SIZE / 3, thr_hi);
        wr_thr(1'b1, SIZE - 2, 1'b1, SIZE);
        chk("thr_err", 20'h00001, thr_err);
        chk("thr_lo", (SIZE / 3) * 2, thr_lo);
        wr_thr(1'b1, SIZE - 3, 1'b1, SIZE - 1);
        chk("thr_err", 20'h00000, thr_err);
        chk("thr_hi", SIZE - 3, thr_hi);
        chk("thr_lo", SIZE - 1, thr_lo);
        rst_n = 1'b0;
        cyc(4);
        rst_n = 1'b1;
        cyc(1);
        chk_rst();
        finish_test();
    end
endmodule
`default_nettype wire
